// *** core/mcs_sequencer.sv ***
// Measurement sequencer: channel scheduling, averaging, result registers, limits and interrupt.
// Assumes the serial front end presents decoded byte accesses and a transfer-active level.
//
// Contract
// - Single-channel mode converts only the selected channel, repeatedly.
// - Round robin converts supply, internal, external, then repeats continuously.
// - Unmasked temperature results outside limits set flags in status one.
// - Any unmasked out-of-limit flag drives the interrupt at configured polarity.
// - Temperatures span -128 to +127 degrees in quarter-degree 10-bit steps.
// - With averaging on, stored temperature is the mean of 16 conversions.
// - Single-channel conversions follow each other without idle gap.
// - Raw conversion takes 712 us internal, 1.51 ms external.
// - Temperature results split over two byte registers, readable when stored.
// - Mode bit 5 disables averaging; averaging is on after reset.
// - Serial traffic aborts conversion, resets ADC, restarts after transfer.
// - Supply low two bits at 03h, high eight bits at 06h.
// - Unmasked supply result outside limits sets a flag in status two.
// - Supply result is unsigned 10-bit, full scale 3FF means 7 volts.
// - Reference amplifier powered only while monitoring is enabled.
// - Reset leaves round robin with monitoring off until enable bit set.
// - Mode bit 4 selects single-channel; clearing returns to round robin.
// - Low select bit set picks internal; else high bit picks external; both zero picks supply.
// - Reading low-bits register freezes paired high bytes until one is read.
// - Temperature results are two's complement.
// - High check is greater than; low check is less than or equal.
`timescale 1ns/1ps
module mcs_sequencer
  import mcs_pkg::*;
#(
  parameter int unsigned INT_CONV_CYC = INT_CONV_CYCLES,
  parameter int unsigned EXT_CONV_CYC = EXT_CONV_CYCLES
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire mcs_reg_req_s regReq,
  output logic [7:0]        regRdData,
  input  wire logic         serialActive,
  input  wire mcs_limits_s  limits,
  output logic              adcStart,
  output logic              adcReset,
  output mcs_chan_e         adcChannel,
  input  wire logic [9:0]   adcData,
  output logic              refPowerOn,
  output logic              intOut
);

  mcs_seq_state_s seqR;
  mcs_seq_state_s seqNxt;
  logic           enabled;
  logic           single;
  logic           avgSample;
  logic           avgClear;
  logic           avgBypass;
  logic           avgLast;
  logic           avgValid;
  logic [9:0]     avgResult;
  logic           anyFlag;
  logic           storeEvt;
  logic           msbRead;
  logic [7:0]     rd;

  function automatic mcs_chan_e selChan(input logic [7:0] mode);
    if (mode[MODE_SEL_LO_BIT]) begin
      selChan = CH_INT;
    end else if (mode[MODE_SEL_HI_BIT]) begin
      selChan = CH_EXT;
    end else begin
      selChan = CH_SUPPLY;
    end
  endfunction : selChan

  function automatic mcs_chan_e rrNext(input mcs_chan_e ch);
    case (ch)
      CH_SUPPLY: rrNext = CH_INT;
      CH_INT:    rrNext = CH_EXT;
      default:   rrNext = CH_SUPPLY;
    endcase
  endfunction : rrNext

  // Wait in cycles for one raw conversion; the supply uses the internal figure.
  function automatic logic [TIMER_W-1:0] convLen(input mcs_chan_e ch);
    if (ch == CH_EXT) begin
      convLen = TIMER_W'(EXT_CONV_CYC);
    end else begin
      convLen = TIMER_W'(INT_CONV_CYC);
    end
  endfunction : convLen

  assign enabled   = seqR.cfg1[CFG1_ENABLE_BIT];
  assign single    = seqR.modeCtrl[MODE_SINGLE_BIT];
  assign avgClear  = serialActive || !enabled;
  assign avgBypass = (seqR.chan == CH_SUPPLY) || seqR.modeCtrl[MODE_AVG_OFF_BIT];
  assign storeEvt  = (seqR.state == ST_STORE) && avgValid;
  assign msbRead   = regReq.re && ((regReq.addr == ADDR_SUPPLY_MSB) ||
                     (regReq.addr == ADDR_INT_MSB) || (regReq.addr == ADDR_EXT_MSB));

  mcs_averager u_avg (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .clear       (avgClear),
    .sampleValid (avgSample),
    .sample      (adcData),
    .bypass      (avgBypass),
    .lastSample  (avgLast),
    .resultValid (avgValid),
    .result      (avgResult)
  );

  always_comb begin
    seqNxt = seqR;
    seqNxt.adcStart = 1'b0;
    seqNxt.adcReset = serialActive;
    avgSample = 1'b0;
    rd = 8'h00;

    // Register writes.
    if (regReq.we) begin
      case (regReq.addr)
        ADDR_CONFIG1:   seqNxt.cfg1 = regReq.wdata;
        ADDR_MODE_CTRL: seqNxt.modeCtrl = regReq.wdata;
        default: ;
      endcase
    end

    // Register reads and their side effects; flag sets below override the clears.
    if (regReq.re) begin
      case (regReq.addr)
        ADDR_STATUS1: begin
          rd = seqR.status1;
          seqNxt.status1 = 8'h00;
        end
        ADDR_STATUS2: begin
          rd = seqR.status2;
          seqNxt.status2 = 8'h00;
        end
        ADDR_SUPPLY_LSB: begin
          rd = {4'h0, seqR.result[CH_INT][1:0], seqR.result[CH_SUPPLY][1:0]};
          seqNxt.lock[CH_SUPPLY] = 1'b1;
          seqNxt.lock[CH_INT] = 1'b1;
        end
        ADDR_TEMP_LSB: begin
          rd = {6'h00, seqR.result[CH_EXT][1:0]};
          seqNxt.lock[CH_EXT] = 1'b1;
        end
        ADDR_SUPPLY_MSB: begin
          rd = seqR.msb[CH_SUPPLY];
          seqNxt.lock = '0;
        end
        ADDR_INT_MSB: begin
          rd = seqR.msb[CH_INT];
          seqNxt.lock = '0;
        end
        ADDR_EXT_MSB: begin
          rd = seqR.msb[CH_EXT];
          seqNxt.lock = '0;
        end
        ADDR_CONFIG1:   rd = seqR.cfg1;
        ADDR_MODE_CTRL: rd = seqR.modeCtrl;
        default:        rd = 8'h00;
      endcase
      seqNxt.rdData = rd;
    end

    // Conversion sequencing.
    case (seqR.state)
      ST_IDLE: begin
        if (enabled && !serialActive) begin
          seqNxt.chan = single ? selChan(seqR.modeCtrl) : seqR.chan;
          seqNxt.state = ST_START;
        end
      end
      ST_START: begin
        seqNxt.adcStart = 1'b1;
        seqNxt.timer = convLen(seqR.chan);
        seqNxt.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (seqR.timer <= TIMER_W'(1)) begin
          avgSample = 1'b1;
          seqNxt.state = avgLast ? ST_STORE : ST_START;
        end else begin
          seqNxt.timer = seqR.timer - TIMER_W'(1);
        end
      end
      ST_STORE: begin
        if (avgValid) begin
          seqNxt.result[seqR.chan] = avgResult;
          if (!seqR.lock[seqR.chan]) begin
            seqNxt.msb[seqR.chan] = avgResult[9:2];
          end
          case (seqR.chan)
            CH_SUPPLY: begin
              if (!limits.maskSup) begin
                if (avgResult[9:2] > limits.supHigh) begin
                  seqNxt.status2[ST2_SUP_HIGH] = 1'b1;
                end
                if (avgResult[9:2] <= limits.supLow) begin
                  seqNxt.status2[ST2_SUP_LOW] = 1'b1;
                end
              end
            end
            CH_INT: begin
              if (!limits.maskInt) begin
                if ($signed(avgResult[9:2]) > $signed(limits.intHigh)) begin
                  seqNxt.status1[ST1_INT_HIGH] = 1'b1;
                end
                if ($signed(avgResult[9:2]) <= $signed(limits.intLow)) begin
                  seqNxt.status1[ST1_INT_LOW] = 1'b1;
                end
              end
            end
            default: begin
              if (!limits.maskExt) begin
                if ($signed(avgResult[9:2]) > $signed(limits.extHigh)) begin
                  seqNxt.status1[ST1_EXT_HIGH] = 1'b1;
                end
                if ($signed(avgResult[9:2]) <= $signed(limits.extLow)) begin
                  seqNxt.status1[ST1_EXT_LOW] = 1'b1;
                end
              end
            end
          endcase
          seqNxt.chan = single ? selChan(seqR.modeCtrl) : rrNext(seqR.chan);
          seqNxt.state = ST_START;
        end
      end
      default: seqNxt.state = ST_IDLE;
    endcase

    // Serial traffic or a disable aborts whatever conversion is running.
    if (serialActive || !enabled) begin
      seqNxt.state = ST_IDLE;
      seqNxt.adcStart = 1'b0;
    end

    anyFlag = (|seqNxt.status1) || (|seqNxt.status2);
    seqNxt.intOut = limits.intActiveHigh ? anyFlag : !anyFlag;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seqR <= SEQ_STATE_RESET;
    end else begin
      seqR <= seqNxt;
    end
  end

  assign regRdData  = seqR.rdData;
  assign adcStart   = seqR.adcStart;
  assign adcReset   = seqR.adcReset;
  assign adcChannel = seqR.chan;
  assign refPowerOn = seqR.cfg1[CFG1_ENABLE_BIT];
  assign intOut     = seqR.intOut;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_single_chan;
    (storeEvt && single && enabled && !serialActive && !regReq.we)
      |=> (adcChannel == selChan(seqR.modeCtrl));
  endproperty
  a_single_chan: assert property (p_single_chan) else $error("Single mode left the selected channel.");

  property p_rr_order;
    (storeEvt && !single && enabled && !serialActive && !regReq.we && seqR.chan == CH_SUPPLY)
      |=> (adcChannel == CH_INT) ##1 (adcStart && adcChannel == CH_INT) or serialActive;
  endproperty
  a_rr_order: assert property (p_rr_order) else $error("Round robin did not follow supply with internal.");

  property p_no_gap;
    (seqR.state == ST_WAIT && seqR.timer <= TIMER_W'(1) && !avgLast && enabled && !serialActive && !regReq.we)
      ##1 !serialActive |=> adcStart;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("Idle gap between conversions.");

  property p_abort;
    serialActive |=> (adcReset && !adcStart);
  endproperty
  a_abort: assert property (p_abort) else $error("Conversion not aborted during serial traffic.");

  property p_restart;
    ($fell(serialActive) && enabled && !regReq.we) ##1 !serialActive |=> adcStart;
  endproperty
  a_restart: assert property (p_restart) else $error("Conversion did not restart after transfer.");

  property p_ref_power;
    (regReq.we && regReq.addr == ADDR_CONFIG1) |=> (refPowerOn == $past(regReq.wdata[CFG1_ENABLE_BIT]));
  endproperty
  a_ref_power: assert property (p_ref_power) else $error("Reference power does not follow enable.");

  property p_int_level;
    $stable(limits.intActiveHigh) |-> (((|seqR.status1) || (|seqR.status2)) == (intOut == limits.intActiveHigh));
  endproperty
  a_int_level: assert property (p_int_level) else $error("Interrupt level disagrees with flags.");

  property p_int_high_flag;
    (storeEvt && seqR.chan == CH_INT && !limits.maskInt && $signed(avgResult[9:2]) > $signed(limits.intHigh))
      |=> seqR.status1[ST1_INT_HIGH];
  endproperty
  a_int_high_flag: assert property (p_int_high_flag) else $error("Internal high flag not set.");

  property p_sup_low_flag;
    (storeEvt && seqR.chan == CH_SUPPLY && !limits.maskSup && avgResult[9:2] <= limits.supLow)
      |=> seqR.status2[ST2_SUP_LOW];
  endproperty
  a_sup_low_flag: assert property (p_sup_low_flag) else $error("Supply low flag not set.");

  property p_lock;
    (seqR.lock[CH_SUPPLY] && !msbRead) |=> $stable(seqR.msb[CH_SUPPLY]);
  endproperty
  a_lock: assert property (p_lock) else $error("Locked supply high byte changed.");

  property p_disabled;
    !enabled |=> !adcStart;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Conversion started while disabled.");

  property p_int_low_flag;
    (storeEvt && seqR.chan == CH_INT && !limits.maskInt && $signed(avgResult[9:2]) <= $signed(limits.intLow))
      |=> seqR.status1[ST1_INT_LOW];
  endproperty
  a_int_low_flag: assert property (p_int_low_flag) else $error("Internal low flag not set.");

  property p_ext_high_flag;
    (storeEvt && seqR.chan == CH_EXT && !limits.maskExt && $signed(avgResult[9:2]) > $signed(limits.extHigh))
      |=> seqR.status1[ST1_EXT_HIGH];
  endproperty
  a_ext_high_flag: assert property (p_ext_high_flag) else $error("External high flag not set.");

  property p_ext_masked;
    (storeEvt && seqR.chan == CH_EXT && limits.maskExt && !(regReq.re && regReq.addr == ADDR_STATUS1))
      |=> $stable(seqR.status1);
  endproperty
  a_ext_masked: assert property (p_ext_masked) else $error("Masked external result changed status one.");

  property p_reset_release;
    !serialActive |=> !adcReset;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("ADC reset held after transfer ended.");

  c_single_store: cover property (storeEvt && single);
  c_rr_ext_store: cover property (storeEvt && !single && seqR.chan == CH_EXT);
  c_abort:        cover property ((seqR.state == ST_WAIT) ##1 serialActive);
  c_lock:         cover property (seqR.lock[CH_SUPPLY] && storeEvt && seqR.chan == CH_SUPPLY);

endmodule : mcs_sequencer

// *** core/mcs_pkg.sv ***
// Shared constants and types for the monitor conversion sequencer.
// Assumes a 100 MHz system clock and an external ADC that converts on a start pulse.
package mcs_pkg;

  // Clock and conversion timing.
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned INT_CONV_NS     = 712000;
  localparam int unsigned EXT_CONV_NS     = 1510000;
  localparam int unsigned INT_CONV_CYCLES = INT_CONV_NS / CLK_PERIOD_NS;
  localparam int unsigned EXT_CONV_CYCLES = EXT_CONV_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W         = 18;

  // Averaging: sixteen raw conversions per stored temperature.
  localparam int unsigned AVG_SHIFT       = 4;
  localparam logic [3:0]  AVG_LAST        = 4'hF;

  // Register offsets.
  localparam logic [7:0] ADDR_STATUS1     = 8'h00;
  localparam logic [7:0] ADDR_STATUS2     = 8'h01;
  localparam logic [7:0] ADDR_SUPPLY_LSB  = 8'h03;
  localparam logic [7:0] ADDR_TEMP_LSB    = 8'h04;
  localparam logic [7:0] ADDR_SUPPLY_MSB  = 8'h06;
  localparam logic [7:0] ADDR_INT_MSB     = 8'h07;
  localparam logic [7:0] ADDR_EXT_MSB     = 8'h08;
  localparam logic [7:0] ADDR_CONFIG1     = 8'h18;
  localparam logic [7:0] ADDR_MODE_CTRL   = 8'h19;

  // Field positions.
  localparam int unsigned CFG1_ENABLE_BIT  = 0;
  localparam int unsigned MODE_SEL_LO_BIT  = 0;
  localparam int unsigned MODE_SEL_HI_BIT  = 1;
  localparam int unsigned MODE_SINGLE_BIT  = 4;
  localparam int unsigned MODE_AVG_OFF_BIT = 5;
  localparam int unsigned ST1_INT_HIGH     = 0;
  localparam int unsigned ST1_INT_LOW      = 1;
  localparam int unsigned ST1_EXT_HIGH     = 2;
  localparam int unsigned ST1_EXT_LOW      = 3;
  localparam int unsigned ST2_SUP_HIGH     = 0;
  localparam int unsigned ST2_SUP_LOW      = 1;

  // Reset values.
  localparam logic [7:0] CONFIG1_RESET    = 8'h00;
  localparam logic [7:0] MODE_CTRL_RESET  = 8'h00;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_STORE} mcs_state_e;
  typedef enum logic [1:0] {CH_SUPPLY, CH_INT, CH_EXT} mcs_chan_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } mcs_reg_req_s;

  typedef struct packed {
    logic [7:0] intHigh;
    logic [7:0] intLow;
    logic [7:0] extHigh;
    logic [7:0] extLow;
    logic [7:0] supHigh;
    logic [7:0] supLow;
    logic       maskInt;
    logic       maskExt;
    logic       maskSup;
    logic       intActiveHigh;
  } mcs_limits_s;

  typedef struct packed {
    logic signed [13:0] acc;
    logic [3:0]         cnt;
    logic               valid;
    logic [9:0]         result;
  } mcs_avg_state_s;

  typedef struct packed {
    mcs_state_e         state;
    mcs_chan_e          chan;
    logic [TIMER_W-1:0] timer;
    logic [7:0]         cfg1;
    logic [7:0]         modeCtrl;
    logic [7:0]         status1;
    logic [7:0]         status2;
    logic [7:0]         rdData;
    logic [2:0][9:0]    result;
    logic [2:0][7:0]    msb;
    logic [2:0]         lock;
    logic               adcStart;
    logic               adcReset;
    logic               intOut;
  } mcs_seq_state_s;

  localparam mcs_seq_state_s SEQ_STATE_RESET = '{state: ST_IDLE, chan: CH_SUPPLY,
    cfg1: CONFIG1_RESET, modeCtrl: MODE_CTRL_RESET, default: '0};

endpackage : mcs_pkg

// *** core/mcs_averager.sv ***
// Sixteen-sample signed accumulator for temperature conversions.
// Assumes one sample strobe per finished raw conversion; bypass passes samples straight through.
`timescale 1ns/1ps
module mcs_averager
  import mcs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       sampleValid,
  input  wire logic [9:0] sample,
  input  wire logic       bypass,
  output logic            lastSample,
  output logic            resultValid,
  output logic [9:0]      result
);

  mcs_avg_state_s     avgR;
  mcs_avg_state_s     avgNxt;
  logic signed [13:0] sum;

  always_comb begin
    avgNxt = avgR;
    avgNxt.valid = 1'b0;
    lastSample = bypass || (avgR.cnt == AVG_LAST);
    sum = avgR.acc + $signed({{4{sample[9]}}, sample});
    if (clear) begin
      avgNxt.acc = '0;
      avgNxt.cnt = '0;
    end else if (sampleValid) begin
      if (lastSample) begin
        avgNxt.valid = 1'b1;
        avgNxt.result = bypass ? sample : sum[13:AVG_SHIFT];
        avgNxt.acc = '0;
        avgNxt.cnt = '0;
      end else begin
        avgNxt.acc = sum;
        avgNxt.cnt = avgR.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avgR <= '0;
    end else begin
      avgR <= avgNxt;
    end
  end

  assign resultValid = avgR.valid;
  assign result      = avgR.result;

endmodule : mcs_averager

// *** tb/mcs_adc_model.sv ***
// ADC stand-in for the sequencer: answers each start pulse with the code of the selected channel.
// Assumes the sequencer samples adcData exactly the conversion time after its start pulse.
`timescale 1ns/1ps
module mcs_adc_model
  import mcs_pkg::*;
#(
  parameter int unsigned INT_CYC = 5,
  parameter int unsigned EXT_CYC = 9
) (
  input  wire logic            sys_clk,
  input  wire logic            adcStart,
  input  wire logic            adcReset,
  input  wire mcs_chan_e       adcChannel,
  input  wire logic [2:0][9:0] codes,
  input  wire logic            wobble,
  output logic [9:0]           adcData
);
  int unsigned left = 0;
  logic        odd  = 1'b0;
  logic [9:0]  held = '0;

  // Alternate samples differ by three codes when wobble is set, so an average is visible.
  always @(posedge sys_clk) begin
    if (adcReset) begin
      left <= 0;
    end else if (adcStart) begin
      left <= (adcChannel == CH_EXT) ? EXT_CYC : INT_CYC;
      held <= codes[adcChannel] + ((wobble && odd) ? 10'h003 : 10'h000);
      odd  <= ~odd;
    end else if (left != 0) begin
      left <= left - 1;
    end
  end

  // Outside a conversion the data lines carry the inverse, so a late sample is caught.
  assign adcData = (left != 0) ? held : ~held;
endmodule : mcs_adc_model

// *** tb/monitor_conversion_sequencer_bench.sv ***
// Self-checking bench for the sequencer with shortened conversion times and an ADC stand-in.
// Assumes the design carries its own assertions; inputs change on the falling clock edge.
`timescale 1ns/1ps
module monitor_conversion_sequencer_bench;
  import mcs_pkg::*;
  localparam int unsigned NI = 5;
  localparam int unsigned NE = 9;
  logic            sys_clk      = 1'b0;
  logic            rst_n        = 1'b0;
  mcs_reg_req_s    regReq       = '0;
  mcs_limits_s     limits       = '{maskInt: 1'b1, maskExt: 1'b1, maskSup: 1'b1, intActiveHigh: 1'b1, default: '0};
  logic            serialActive = 1'b0;
  logic            wobble       = 1'b0;
  logic [2:0][9:0] codes        = '0;
  logic [7:0]      regRdData;
  logic            adcStart;
  logic            adcReset;
  logic            refPowerOn;
  logic            intOut;
  mcs_chan_e       adcChannel;
  logic [9:0]      adcData;
  logic [31:0]     rnd          = 32'h05C4;
  int              err_count    = 0;
  int              checks       = 0;
  mcs_chan_e       lastChan;
  time             lastT;
  time             t0;
  logic [7:0]      rb;
  logic [9:0]      e;
  int              selExp[4]    = '{0, 1, 2, 1};

  mcs_sequencer #(.INT_CONV_CYC(NI), .EXT_CONV_CYC(NE)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
    .regRdData(regRdData), .serialActive(serialActive), .limits(limits), .adcStart(adcStart),
    .adcReset(adcReset), .adcChannel(adcChannel), .adcData(adcData), .refPowerOn(refPowerOn), .intOut(intOut));
  mcs_adc_model #(.INT_CYC(NI), .EXT_CYC(NE)) adc (.sys_clk(sys_clk), .adcStart(adcStart), .adcReset(adcReset),
    .adcChannel(adcChannel), .codes(codes), .wobble(wobble), .adcData(adcData));

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Mean of sixteen samples alternating between v and v + d, truncated toward minus infinity.
  function automatic logic [9:0] avg16(input logic [9:0] v, input logic [9:0] d);
    logic signed [13:0] acc;
    acc = '0;
    for (int i = 0; i < 16; i++) acc += 14'(signed'(v + ((i % 2) ? d : 10'h000)));
    return 10'(acc >>> 4);
  endfunction : avg16

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regReq = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(negedge sys_clk);
    regReq.we = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    regReq = '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(negedge sys_clk);
    regReq.re = 1'b0;
    rb = regRdData;
  endtask : rd

  task automatic starts(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 2000) begin
      @(negedge sys_clk);
      k++;
      if (adcStart === 1'b1) begin
        n--;
        lastChan = adcChannel;
        lastT = $time;
      end
    end
    chk(10'(k < 2000), 10'h001, "start wait");
  endtask : starts

  task automatic quiet(input int n);
    int hit;
    hit = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (adcStart !== 1'b0) hit++;
    end
    chk(10'(hit), 10'h000, "start while stopped");
  endtask : quiet

  task automatic end_of_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #200000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(ADDR_CONFIG1);
    chk(10'(rb), 10'h000, "config reset");
    rd(ADDR_MODE_CTRL);
    chk(10'(rb), 10'h000, "mode reset");
    rd(8'h02);
    chk(10'(rb), 10'h000, "unmapped read");
    chk(10'(refPowerOn), 10'h000, "reference off");
    quiet(30);
    rnd = lfsr(rnd);
    codes[0] = rnd[9:0];
    // Internal code stays at or above -64 degrees so its high limit minus one cannot wrap.
    codes[1] = {2'b11, rnd[17:12], 2'b00};
    codes[2] = {1'b0, rnd[25:19], 2'b00};
    wr(ADDR_MODE_CTRL, 8'h20);
    wr(ADDR_CONFIG1, 8'h01);
    chk(10'(refPowerOn), 10'h001, "reference on");
    starts(1);
    chk(10'(lastChan), 10'(CH_SUPPLY), "first channel");
    for (int i = 1; i < 7; i++) begin
      starts(1);
      chk(10'(lastChan), 10'(i % 3), "round robin order");
    end
    rd(ADDR_SUPPLY_MSB);
    chk(10'(rb), 10'(codes[0][9:2]), "supply high byte");
    rd(ADDR_INT_MSB);
    chk(10'(rb), 10'(codes[1][9:2]), "internal high byte");
    rd(ADDR_EXT_MSB);
    chk(10'(rb), 10'(codes[2][9:2]), "external high byte");
    rd(ADDR_SUPPLY_LSB);
    chk(10'(rb[3:0]), 10'({codes[1][1:0], codes[0][1:0]}), "low bits");
    rd(ADDR_TEMP_LSB);
    chk(10'(rb[1:0]), 10'(codes[2][1:0]), "external low bits");
    rd(ADDR_SUPPLY_MSB);
    limits = '{intHigh: codes[1][9:2] - 8'h01, intLow: codes[1][9:2], extHigh: codes[2][9:2] - 8'h01,
      extLow: codes[2][9:2] - 8'h01, supHigh: codes[0][9:2], supLow: codes[0][9:2], intActiveHigh: 1'b1, default: '0};
    starts(4);
    chk(10'(intOut), 10'h001, "interrupt high");
    limits.intActiveHigh = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(10'(intOut), 10'h000, "interrupt low");
    limits.intActiveHigh = 1'b1;
    rd(ADDR_STATUS1);
    chk(10'(rb), 10'h007, "temperature flags");
    rd(ADDR_STATUS2);
    chk(10'(rb), 10'h002, "supply flags");
    {limits.maskInt, limits.maskExt, limits.maskSup} = 3'b111;
    starts(4);
    rd(ADDR_STATUS1);
    rd(ADDR_STATUS2);
    rd(ADDR_STATUS1);
    chk(10'(rb), 10'h000, "masked temperature flags");
    rd(ADDR_STATUS2);
    chk(10'(rb), 10'h000, "masked supply flags");
    chk(10'(intOut), 10'h000, "interrupt idle");
    e = codes[0];
    codes[0] = codes[0] ^ 10'h155;
    rd(ADDR_SUPPLY_LSB);
    starts(4);
    rd(ADDR_SUPPLY_MSB);
    chk(10'(rb), 10'(e[9:2]), "locked high byte");
    starts(4);
    rd(ADDR_SUPPLY_MSB);
    chk(10'(rb), 10'(codes[0][9:2]), "unlocked high byte");
    rd(ADDR_SUPPLY_LSB);
    chk(10'(rb[1:0]), 10'(codes[0][1:0]), "new low bits");
    rd(ADDR_SUPPLY_MSB);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_MODE_CTRL, 8'h30 | 8'(s));
      starts(2);
      for (int i = 0; i < 3; i++) begin
        t0 = lastT;
        starts(1);
        chk(10'(lastChan), 10'(selExp[s]), "single channel");
        chk(10'((lastT - t0) / 10), 10'((lastChan == CH_EXT ? NE : NI) + 2), "single gap");
      end
    end
    starts(1);
    serialActive = 1'b1;
    @(negedge sys_clk);
    chk(10'(adcReset), 10'h001, "adc reset in transfer");
    quiet(20);
    serialActive = 1'b0;
    t0 = $time;
    starts(1);
    chk(10'(lastT - t0 <= 30), 10'h001, "restart after transfer");
    rnd = lfsr(rnd);
    codes[1] = {2'b11, rnd[7:0]};
    wobble = 1'b1;
    e = avg16(codes[1], 10'h003);
    wr(ADDR_MODE_CTRL, 8'h11);
    serialActive = 1'b1;
    @(negedge sys_clk);
    serialActive = 1'b0;
    starts(40);
    rd(ADDR_INT_MSB);
    chk(10'(rb), 10'(e[9:2]), "averaged high byte");
    rd(ADDR_SUPPLY_LSB);
    chk(10'(rb[3:2]), 10'(e[1:0]), "averaged low bits");
    rd(ADDR_SUPPLY_MSB);
    wr(ADDR_CONFIG1, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk(10'(refPowerOn), 10'h000, "reference off again");
    quiet(40);
    end_of_test();
  end
endmodule : monitor_conversion_sequencer_bench
